// ---- hw/iopcn_pkg.sv ----
// Shared constants and types for the I/O port with change notice.
// Assumes a single system clock and a plain byte-addressed register port.
package iopcn_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_W = 16;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Register byte offsets; base register at +0, companions follow
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ANALOG_SELECT = 8'h00;
    localparam logic [7:0] OFS_PIN_DIRECTION = 8'h10;
    localparam logic [7:0] OFS_PIN_STATE = 8'h20;
    localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h30;
    localparam logic [7:0] OFS_OPEN_DRAIN = 8'h40;
    localparam logic [7:0] OFS_CN_CONTROL = 8'h70;
    localparam logic [7:0] OFS_CN_ENABLE_LOW = 8'h80;
    localparam logic [7:0] OFS_CN_STATUS = 8'h90;
    localparam logic [7:0] OFS_CN_ENABLE_HIGH = 8'hA0;
    localparam logic [7:0] OFS_CN_EVENT_FLAG = 8'hB0;

    // ------------------------------------------------------------
    // Companion operation, taken from address bits 3:2
    // ------------------------------------------------------------
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CN_ON_BIT = 15;
    localparam int CN_STYLE_BIT = 11;
    localparam logic DIRECTION_RST_BIT = 1'b1;
    localparam logic ANALOG_RST_BIT = 1'b1;
    localparam logic OTHER_RST_BIT = 1'b0;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    // ------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } iopcn_req_s;

endpackage : iopcn_pkg

// ---- hw/iopcn_sync.sv ----
// Pin sampler: a two-flop synchroniser followed by one capture stage.
// Assumes pins are asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module iopcn_sync #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] q_r;

    // ------------------------------------------------------------
    // Stages; only sync_r reads meta_r
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
            q_r <= sync_r;
        end
    end

    assign q = q_r;
endmodule : iopcn_sync
`default_nettype wire

// ---- hw/iopcn_port.sv ----
// I/O port with direction, latch, open-drain, analog select and
// change notification, reached over a plain register port.
// Assumes pins are asynchronous and software obeys the read spacing.
//
// Contract
// - Clear, set, invert companions change only bits written as one.
// - Companion reads return zero; read base register instead.
// - Direction bit one makes a pin input, zero makes it output.
// - Reset makes every pin an input.
// - Latch drives output pins; pin state reads pins, writes go to latch.
// - Pin state is seen three system clocks after a pin change.
// - Open-drain pins drive only low and release for a one.
// - Analog pins read as zero in pin state.
// - Analog select resets to all ones.
// - Output with analog select still drives its digital level.
// - Change detection raises a wake request with clocks stopped.
// - Change notification works only while control bit 15 is set.
// - Style clear: low enable set flags mismatch against last read level.
// - Style set: enables pick none, rising, falling or both edges.
// - Change status marks pins changed since pin state last read.
// - Sticky event flag per pin; software clears it for next request.
// - Requests come only from pins configured as inputs.
`timescale 1ns/1ns
`default_nettype none
module iopcn_port
    import iopcn_pkg::*;
#(
    parameter int N = iopcn_pkg::PIN_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire iopcn_pkg::iopcn_req_s req,
    output logic [iopcn_pkg::DATA_W-1:0] rdata,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] pin_out,
    output logic [N-1:0] pin_oe_n,
    output logic cn_irq,
    output logic cn_wake
);
    import iopcn_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [N-1:0] analog_select_r;
    logic [N-1:0] pin_direction_r;
    logic [N-1:0] output_latch_r;
    logic [N-1:0] open_drain_select_r;
    logic cn_on_r;
    logic edge_style_select_r;
    logic [N-1:0] change_enable_low_r;
    logic [N-1:0] change_enable_high_r;
    logic [N-1:0] change_status_r;
    logic [N-1:0] change_event_flag_r;
    logic [N-1:0] last_read_r;
    logic [N-1:0] prev_r;
    logic [DATA_W-1:0] rdata_r;

    // ------------------------------------------------------------
    // Derived signals
    // ------------------------------------------------------------
    logic [N-1:0] pin_state;
    logic [N-1:0] wd;
    logic [3:0] base_sel;
    logic [1:0] op;
    logic base_op;
    logic [N-1:0] ev;
    logic [N-1:0] cn_set;
    logic [N-1:0] changed;
    logic [N-1:0] wake_ref;
    logic [N-1:0] change_status_nxt;
    logic [N-1:0] change_event_flag_nxt;
    logic [N-1:0] cn_ctl_nxt;
    logic state_read;
    logic [DATA_W-1:0] rdata_nxt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Bits 7:4 pick the register, bits 3:2 the companion
    assign base_sel = req.addr[7:4];
    assign op = req.addr[3:2];
    assign base_op = (op == OP_WRITE);
    assign wd = req.wdata[N-1:0];

    function automatic logic hit(input logic [3:0] sel,
                                 input logic [7:0] ofs);
        hit = (sel == ofs[7:4]);
    endfunction : hit

    // One function serves every writable register so all four ops act alike
    function automatic logic [N-1:0] apply(input logic [N-1:0] old,
                                           input logic [1:0] kind,
                                           input logic [N-1:0] val);
        logic [N-1:0] res;
        res = old;
        case (kind)
            OP_WRITE: begin
                res = val;
            end
            OP_CLR: begin
                res = old & ~val;
            end
            OP_SET: begin
                res = old | val;
            end
            OP_INV: begin
                res = old ^ val;
            end
            default: begin
                res = old;
            end
        endcase
        apply = res;
    endfunction : apply

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    iopcn_sync #(
        .W(N)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(pin_in),
        .q(pin_state)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= pin_state;
        end
    end

    assign state_read = req.rd && hit(base_sel, OFS_PIN_STATE) && base_op;

    // Reference level for mismatch detection, taken at each pin state read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_read_r <= '0;
        end else if (state_read) begin
            last_read_r <= pin_state;
        end
    end

    // ------------------------------------------------------------
    // Pin configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            analog_select_r <= {N{ANALOG_RST_BIT}};
        end else if (req.wr && hit(base_sel, OFS_ANALOG_SELECT)) begin
            analog_select_r <= apply(analog_select_r, op, wd);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_direction_r <= {N{DIRECTION_RST_BIT}};
        end else if (req.wr && hit(base_sel, OFS_PIN_DIRECTION)) begin
            pin_direction_r <= apply(pin_direction_r, op, wd);
        end
    end

    // Writes to pin state land in the latch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            output_latch_r <= {N{OTHER_RST_BIT}};
        end else if (req.wr && (hit(base_sel, OFS_OUTPUT_LATCH) ||
                                hit(base_sel, OFS_PIN_STATE))) begin
            output_latch_r <= apply(output_latch_r, op, wd);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            open_drain_select_r <= {N{OTHER_RST_BIT}};
        end else if (req.wr && hit(base_sel, OFS_OPEN_DRAIN)) begin
            open_drain_select_r <= apply(open_drain_select_r, op, wd);
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Analog select does not gate the driver, so an output pin keeps
    // its digital level for the analog side to use
    assign pin_out = output_latch_r & ~open_drain_select_r;
    // Enable low means driven; open-drain releases for a one
    assign pin_oe_n = pin_direction_r |
                      (open_drain_select_r & output_latch_r);

    // ------------------------------------------------------------
    // Change notice control and enables
    // ------------------------------------------------------------
    // Both control bits pass the shared op so companions act alike
    assign cn_ctl_nxt = apply({{(N-2){1'b0}}, cn_on_r, edge_style_select_r},
                              op, {{(N-2){1'b0}}, req.wdata[CN_ON_BIT],
                                   req.wdata[CN_STYLE_BIT]});
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cn_on_r <= OTHER_RST_BIT;
            edge_style_select_r <= OTHER_RST_BIT;
        end else if (req.wr && hit(base_sel, OFS_CN_CONTROL)) begin
            cn_on_r <= cn_ctl_nxt[1];
            edge_style_select_r <= cn_ctl_nxt[0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            change_enable_low_r <= {N{OTHER_RST_BIT}};
        end else if (req.wr && hit(base_sel, OFS_CN_ENABLE_LOW)) begin
            change_enable_low_r <= apply(change_enable_low_r, op, wd);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            change_enable_high_r <= {N{OTHER_RST_BIT}};
        end else if (req.wr && hit(base_sel, OFS_CN_ENABLE_HIGH)) begin
            change_enable_high_r <= apply(change_enable_high_r, op, wd);
        end
    end

    // ------------------------------------------------------------
    // Per-pin event detection
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_pin
        logic rise;
        logic fall;
        assign rise = pin_state[i] & ~prev_r[i];
        assign fall = ~pin_state[i] & prev_r[i];
        assign changed[i] = rise | fall;
        always_comb begin
            if (edge_style_select_r) begin
                ev[i] = (change_enable_low_r[i] & rise) |
                        (change_enable_high_r[i] & fall);
            end else begin
                ev[i] = change_enable_low_r[i] &
                        (pin_state[i] ^ last_read_r[i]);
            end
        end
        assign cn_set[i] = cn_on_r & pin_direction_r[i] &
                           ev[i];
    end

    // ------------------------------------------------------------
    // Status and sticky flags; a hardware set beats a clear
    // ------------------------------------------------------------
    always_comb begin
        change_status_nxt = change_status_r;
        if (state_read) begin
            change_status_nxt = '0;
        end
        change_status_nxt = change_status_nxt |
                            ({N{cn_on_r}} & changed);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            change_status_r <= {N{OTHER_RST_BIT}};
        end else begin
            change_status_r <= change_status_nxt;
        end
    end

    always_comb begin
        change_event_flag_nxt = change_event_flag_r;
        if (req.wr && hit(base_sel, OFS_CN_EVENT_FLAG)) begin
            change_event_flag_nxt = apply(change_event_flag_r, op, wd);
        end
        change_event_flag_nxt = change_event_flag_nxt | cn_set;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            change_event_flag_r <= {N{OTHER_RST_BIT}};
        end else begin
            change_event_flag_r <= change_event_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and wake requests
    // ------------------------------------------------------------
    assign cn_irq = cn_on_r &
                    |(change_event_flag_r & pin_direction_r);

    // Wake must work with clk_sys stopped, so this path looks at the
    // raw pins; it is a level for the power controller, not for logic
    // on clk_sys, and may glitch while a pin is moving
    assign wake_ref = edge_style_select_r ? pin_state : last_read_r;
    assign cn_wake = cn_irq | (cn_on_r & |(pin_direction_r &
                     (change_enable_low_r | change_enable_high_r) &
                     (pin_in ^ wake_ref)));

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = RDATA_NONE;
        // Companion and unmapped reads answer zero
        if (req.rd && base_op) begin
            case (base_sel)
                OFS_ANALOG_SELECT[7:4]: begin
                    rdata_nxt[N-1:0] = analog_select_r;
                end
                OFS_PIN_DIRECTION[7:4]: begin
                    rdata_nxt[N-1:0] = pin_direction_r;
                end
                OFS_PIN_STATE[7:4]: begin
                    rdata_nxt[N-1:0] = pin_state &
                                       ~analog_select_r;
                end
                OFS_OUTPUT_LATCH[7:4]: begin
                    rdata_nxt[N-1:0] = output_latch_r;
                end
                OFS_OPEN_DRAIN[7:4]: begin
                    rdata_nxt[N-1:0] = open_drain_select_r;
                end
                OFS_CN_CONTROL[7:4]: begin
                    rdata_nxt[CN_ON_BIT] = cn_on_r;
                    rdata_nxt[CN_STYLE_BIT] = edge_style_select_r;
                end
                OFS_CN_ENABLE_LOW[7:4]: begin
                    rdata_nxt[N-1:0] = change_enable_low_r;
                end
                OFS_CN_STATUS[7:4]: begin
                    rdata_nxt[N-1:0] = change_status_r;
                end
                OFS_CN_ENABLE_HIGH[7:4]: begin
                    rdata_nxt[N-1:0] = change_enable_high_r;
                end
                OFS_CN_EVENT_FLAG[7:4]: begin
                    rdata_nxt[N-1:0] = change_event_flag_r;
                end
                default: begin
                    rdata_nxt = RDATA_NONE;
                end
            endcase
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= RDATA_NONE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule : iopcn_port
`default_nettype wire

// ---- test/iopcn_port_asserts.sv ----
// Concurrent checks on the I/O port: bus, direction, drive and request.
// Assumes it is bound to iopcn_port and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module iopcn_port_asserts
    import iopcn_pkg::*;
#(
    parameter int N = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire iopcn_pkg::iopcn_req_s req,
    input wire logic [iopcn_pkg::DATA_W-1:0] rdata,
    input wire logic [N-1:0] pin_in,
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_oe_n,
    input wire logic cn_irq,
    input wire logic cn_wake
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_rdata_idle: assert property (
        !req.rd |=> rdata == '0) else $error("read data not idle");
    a_comp_read_zero: assert property (
        req.rd && req.addr[3:2] != 2'h0 |=> rdata == '0)
        else $error("companion read not zero");
    a_dir_set_input: assert property (
        req.wr && req.addr == (OFS_PIN_DIRECTION | 8'h08) |=>
        (pin_oe_n & $past(req.wdata[N-1:0])) == $past(req.wdata[N-1:0]))
        else $error("set pin not released");
    a_reset_input: assert property (
        $fell(rst) |-> pin_oe_n == '1) else $error("pin driven after reset");
    a_od_low: assert property (
        req.wr && req.addr == (OFS_OPEN_DRAIN | 8'h08) &&
        req.wdata[N-1:0] == '1 |=> pin_out == '0)
        else $error("open drain drives high");
    a_cn_off_quiet: assert property (
        req.wr && req.addr == OFS_CN_CONTROL && !req.wdata[CN_ON_BIT] |=>
        !cn_irq) else $error("request while disabled");
    a_irq_input: assert property (
        cn_irq |-> pin_oe_n != '0) else $error("request with no input");
    a_wake_irq: assert property (
        cn_irq |-> cn_wake) else $error("request without wake");
endmodule : iopcn_port_asserts

bind iopcn_port iopcn_port_asserts #(.N(N)) u_asserts (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .cn_irq(cn_irq), .cn_wake(cn_wake));
`default_nettype wire

// ---- test/iopcn_pins.sv ----
// Model of the board at the port pins: pull-ups and an outside driver.
// Assumes one resolved level per pin, fed back to the port's pin inputs.
`timescale 1ns/1ns
`default_nettype none
module iopcn_pins #(
    parameter int N = 16
) (
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_oe_n,
    input wire logic [N-1:0] ext_val,
    input wire logic [N-1:0] ext_oe,
    output logic [N-1:0] level
);
    // ------------------------------------------------------------
    // Resolution
    // ------------------------------------------------------------
    // Port wins a clash; a released line never keeps its last value
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!pin_oe_n[i]) begin
                level[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                level[i] = ext_val[i];
            end else begin
                level[i] = 1'b1;
            end
        end
    end
endmodule : iopcn_pins
`default_nettype wire

// ---- test/test_io_port_with_change_notice.sv ----
// Self-checking bench for the I/O port with change notification.
// Assumes iopcn_pkg, iopcn_port, iopcn_pins and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module test_io_port_with_change_notice;
    import iopcn_pkg::*;
    localparam int N = 16;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    iopcn_req_s req = '0;
    logic [DATA_W-1:0] rdata;
    logic [N-1:0] pin_in, pin_out, pin_oe_n;
    logic cn_irq, cn_wake;
    logic [N-1:0] ext_val = '0;
    logic [N-1:0] ext_oe = '0;
    logic [7:0] rw_a [6] = '{OFS_ANALOG_SELECT, OFS_PIN_DIRECTION,
        OFS_OUTPUT_LATCH, OFS_OPEN_DRAIN, OFS_CN_ENABLE_LOW, OFS_CN_ENABLE_HIGH};
    logic [15:0] p, d, sh;
    logic [1:0] op;
    logic [31:0] v;
    int fails = 0;
    int checked = 0;

    always #50 clk_sys = ~clk_sys;

    iopcn_port #(.N(N)) dut (.clk_sys(clk_sys), .rst(rst), .req(req),
        .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .cn_irq(cn_irq), .cn_wake(cn_wake));
    iopcn_pins #(.N(N)) pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_val(ext_val), .ext_oe(ext_oe), .level(pin_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        #1;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe is taken
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), e, rdata);
    endtask : bus_rd

    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
    endtask : do_reset

    task automatic pins_to(input logic [15:0] x);
        @(posedge clk_sys);
        ext_val <= x;
        repeat (6) @(posedge clk_sys);
    endtask : pins_to

    function automatic logic [15:0] apply_op(input logic [15:0] o,
        input logic [1:0] k, input logic [15:0] w);
        case (k)
            OP_CLR: return o & ~w;
            OP_SET: return o | w;
            OP_INV: return o ^ w;
            default: return w;
        endcase
    endfunction : apply_op

    function automatic logic [15:0] ev(input int m, input logic [15:0] r,
                                       input logic [15:0] f);
        return ({16{m[0]}} & r) | ({16{m[1]}} & f);
    endfunction : ev

    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #(100 * 6000);
        fails++;
        end_sim();
    end

    initial begin
        void'($urandom(32'hBBFAC45D));
        do_reset();
        check("pin_oe_n", 32'h0000FFFF, {16'h0, pin_oe_n});
        bus_rd(OFS_CN_CONTROL, 32'h0);
        bus_rd(OFS_CN_EVENT_FLAG, 32'h0);
        bus_wr(OFS_CN_STATUS, 32'hFFFF);
        bus_rd(OFS_CN_STATUS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            sh = (i < 2) ? 16'hFFFF : 16'h0;
            bus_rd(rw_a[i], {16'h0, sh});
            repeat (6) begin
                op = 2'($urandom);
                v = $urandom;
                sh = apply_op(sh, op, v[15:0]);
                bus_wr(rw_a[i] | {4'h0, op, 2'h0}, v);
                bus_rd(rw_a[i], {16'h0, sh});
            end
            bus_rd(rw_a[i] | 8'h0C, 32'h0);
        end
        do_reset();
        // Outputs with analog select still set, then digital use
        d = 16'($urandom);
        bus_wr(OFS_PIN_STATE, {16'h0, d});
        bus_wr(OFS_PIN_DIRECTION | 8'h04, 32'hFFFF);
        check("pin_out", {16'h0, d}, {16'h0, pin_out});
        check("pin_oe_n", 32'h0, {16'h0, pin_oe_n});
        repeat (4) @(posedge clk_sys);
        bus_rd(OFS_PIN_STATE, 32'h0);
        bus_wr(OFS_ANALOG_SELECT | 8'h04, 32'hFFFF);
        bus_rd(OFS_PIN_STATE, {16'h0, d});
        bus_wr(OFS_OPEN_DRAIN | 8'h08, 32'hFFFF);
        check("pin_oe_n", {16'h0, d}, {16'h0, pin_oe_n});
        repeat (4) @(posedge clk_sys);
        bus_rd(OFS_PIN_STATE, {16'h0, d});
        bus_wr(OFS_ANALOG_SELECT | 8'h08, 32'h00FF);
        bus_rd(OFS_PIN_STATE, {16'h0, d & 16'hFF00});
        // Pin sampling delay, outside driver on every pin
        bus_wr(OFS_ANALOG_SELECT | 8'h04, 32'hFFFF);
        bus_wr(OFS_PIN_DIRECTION | 8'h08, 32'hFFFF);
        ext_oe <= 16'hFFFF;
        pins_to(16'h0);
        p = 16'($urandom) | 16'h1;
        @(posedge clk_sys);
        ext_val <= p;
        bus_rd(OFS_PIN_STATE, 32'h0);
        bus_rd(OFS_PIN_STATE, {16'h0, p});
        pins_to(16'h0);
        // Edge style, every enable pair
        for (int m = 0; m < 4; m++) begin
            bus_wr(OFS_CN_CONTROL, 32'h0000_8800);
            bus_wr(OFS_CN_ENABLE_LOW, m[0] ? 32'hFFFF : 32'h0);
            bus_wr(OFS_CN_ENABLE_HIGH, m[1] ? 32'hFFFF : 32'h0);
            bus_wr(OFS_CN_EVENT_FLAG | 8'h04, 32'hFFFF);
            pins_to(p);
            bus_rd(OFS_CN_EVENT_FLAG, {16'h0, ev(m, p, 16'h0)});
            check("cn_irq", {31'h0, m[0]}, {31'h0, cn_irq});
            check("cn_wake", {31'h0, m[0]}, {31'h0, cn_wake});
            bus_wr(OFS_CN_EVENT_FLAG | 8'h04, 32'hFFFF);
            check("cn_irq", 32'h0, {31'h0, cn_irq});
            // Wake follows the raw pin before the sampler catches up
            @(posedge clk_sys);
            ext_val <= 16'h0;
            #1;
            check("cn_wake", {31'h0, m != 0}, {31'h0, cn_wake});
            repeat (6) @(posedge clk_sys);
            bus_rd(OFS_CN_EVENT_FLAG, {16'h0, ev(m, 16'h0, p)});
            bus_rd(OFS_CN_EVENT_FLAG, {16'h0, ev(m, 16'h0, p)});
        end
        // Mismatch style against the last read level
        bus_wr(OFS_CN_CONTROL, 32'h0000_8000);
        bus_rd(OFS_PIN_STATE, 32'h0);
        bus_wr(OFS_CN_EVENT_FLAG | 8'h04, 32'hFFFF);
        pins_to(p);
        bus_rd(OFS_CN_EVENT_FLAG, {16'h0, p});
        bus_rd(OFS_CN_STATUS, {16'h0, p});
        bus_rd(OFS_PIN_STATE, {16'h0, p});
        bus_rd(OFS_CN_STATUS, 32'h0);
        // Notification switched off
        bus_wr(OFS_CN_CONTROL, 32'h0000_0800);
        bus_wr(OFS_CN_EVENT_FLAG | 8'h04, 32'hFFFF);
        pins_to(~p);
        bus_rd(OFS_CN_EVENT_FLAG, 32'h0);
        // Output pins raise nothing
        bus_wr(OFS_CN_CONTROL, 32'h0000_8800);
        bus_wr(OFS_OPEN_DRAIN | 8'h04, 32'hFFFF);
        bus_wr(OFS_PIN_DIRECTION | 8'h04, 32'hFFFF);
        repeat (6) @(posedge clk_sys);
        bus_wr(OFS_CN_EVENT_FLAG | 8'h04, 32'hFFFF);
        bus_wr(OFS_OUTPUT_LATCH | 8'h0C, 32'hFFFF);
        repeat (6) @(posedge clk_sys);
        bus_rd(OFS_CN_EVENT_FLAG, 32'h0);
        check("cn_irq", 32'h0, {31'h0, cn_irq});
        end_sim();
    end
endmodule : test_io_port_with_change_notice
`default_nettype wire
